/* hdl/microcore_pkg.sv */
// Shared types and constants for the jump, wait and load unit.
// Assumes one clock domain; the instruction word arrives already split into fields.
`default_nettype none
package microcore_pkg;

	// Widths
	localparam int ADDR_W       = 10;
	localparam int COND_W       = 6;
	localparam int REL_W        = 6;
	localparam int DATA_W       = 16;
	localparam int REG_SEL_W    = 5;
	localparam int WAIT_ENTRIES = 5;
	localparam int ENTRY_W      = 3;
	localparam int CNT_SEL_W    = 2;
	localparam int NUM_END_CNT  = 4;
	localparam int CTRL_W       = 4;
	localparam int PROD_W       = 32;
	localparam int NUM_COND     = 64;

	// Reset values and steps
	localparam logic [ADDR_W-1:0] PC_RESET   = 10'h000;
	localparam logic [ADDR_W-1:0] PC_STEP    = 10'h001;
	localparam logic [ADDR_W-1:0] FAR_RESET  = 10'h000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam logic [PROD_W-1:0] PROD_RESET = 32'h0000_0000;

	// Opcodes seen by this unit
	typedef enum logic [3:0] {
		OP_NOP   = 4'h0,
		OP_JMPR  = 4'h1,
		OP_JMPF  = 4'h2,
		OP_CWEF  = 4'h3,
		OP_CWER  = 4'h4,
		OP_WAIT  = 4'h5,
		OP_LOAD  = 4'h6,
		OP_STORE = 4'h7,
		OP_COPY  = 4'h8,
		OP_LDCA  = 4'h9,
		OP_LDCD  = 4'hA,
		OP_LDPH  = 4'hB,
		OP_LDPL  = 4'hC,
		OP_LDFA  = 4'hD,
		OP_LDFB  = 4'hE
	} op_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_WAIT = 2'b10
	} state_t;

	// Decoded instruction word
	typedef struct packed {
		op_t                  op;
		logic                 far_sel;
		logic [REL_W-1:0]     rel_off;
		logic [ENTRY_W-1:0]   entry;
		logic [COND_W-1:0]    cond;
		logic [WAIT_ENTRIES-1:0] wait_mask;
		logic [REG_SEL_W-1:0] src_sel;
		logic [REG_SEL_W-1:0] dst_sel;
		logic [CNT_SEL_W-1:0] cnt_sel;
		logic [ADDR_W-1:0]    ram_addr;
		logic [DATA_W-1:0]    imm;
	} instr_t;

	// One wait table entry
	typedef struct packed {
		logic              enable;
		logic [COND_W-1:0] cond;
		logic [ADDR_W-1:0] dest;
	} wait_entry_t;

	// Wait table configuration write
	typedef struct packed {
		logic               we;
		logic [ENTRY_W-1:0] idx;
		logic [COND_W-1:0]  cond;
		logic [ADDR_W-1:0]  dest;
	} wait_cfg_t;

	// Signed offset applied to a code address, wrapped to the code space
	function automatic logic [ADDR_W-1:0] rel_target(input logic [ADDR_W-1:0] base,
		input logic [REL_W-1:0] off);
		logic [ADDR_W-1:0] ext;
		ext = {{(ADDR_W-REL_W){off[REL_W-1]}}, off};
		rel_target = base + ext;
	endfunction

endpackage
`default_nettype wire

/* hdl/wait_table_store.sv */
// Five-entry wait table held in flip-flops, read out registered.
// Assumes configuration and enable writes never come in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module wait_table_store
	import microcore_pkg::*;
#(
	parameter int ENTRIES = WAIT_ENTRIES
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Writes
	input  wire microcore_pkg::wait_cfg_t  cfg,
	input  wire logic                      mask_we,
	input  wire logic [ENTRIES-1:0]        mask,
	// Contents
	output microcore_pkg::wait_entry_t     table_q [ENTRIES]
);

	// Entry update; a wait never wipes conditions or destinations
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < ENTRIES; i++) begin
				table_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < ENTRIES; i++) begin
				if (cfg.we && cfg.idx == ENTRY_W'(i)) begin
					table_q[i].cond <= cfg.cond;
					table_q[i].dest <= cfg.dest;
				end
				if (mask_we) begin
					table_q[i].enable <= mask[i];
				end
			end
		end
	end

endmodule
`default_nettype wire

/* hdl/wait_condition_match.sv */
// Tests every enabled wait entry against the condition vector.
// Lowest entry wins when several fire in one cycle.
`timescale 1ns/1ps
`default_nettype none
module wait_condition_match
	import microcore_pkg::*;
#(
	parameter int ENTRIES = WAIT_ENTRIES
) (
	// Table and conditions
	input  wire microcore_pkg::wait_entry_t table_q [ENTRIES],
	input  wire logic [NUM_COND-1:0]        cond_in,
	// Result
	output logic                            hit,
	output logic [ADDR_W-1:0]               dest
);

	// Priority scan from the top so entry 0 overrides
	always_comb begin
		hit  = 1'b0;
		dest = PC_RESET;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (table_q[i].enable && cond_in[table_q[i].cond]) begin
				hit  = 1'b1;
				dest = table_q[i].dest;
			end
		end
	end

endmodule
`default_nettype wire

/* hdl/microcore_jump_wait_load_unit.sv */
// Jump, wait table and load/store/copy execution for one microcore.
// Assumes code RAM, data RAM and register file answer reads combinationally
// and take writes on the next clock edge; instructions come one per cycle.
// The outside reset is asynchronous; every flop after the two-stage synchronizer uses its copy.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RULE1) Relative jump adds offset to program counter
// (RULE2) Relative jump takes one clock
// (RULE3) Far jump loads selected far-target register
// (RULE4) Far jump keeps far-target register intact
// (RULE5) Far jump takes one clock
// (RULE6) Five wait entries: enable, condition, destination
// (RULE7) Wait destinations stored as physical addresses
// (RULE8) One configuration instruction programs one entry
// (RULE9) Wait does not clear the table
// (RULE10) Wait holds counter until enabled condition fires
// (RULE11) Fired wait branches to stored destination
// (RULE12) Conditions ignored after wait completes
// (RULE13) Wait instruction sets entry enable bits
// (RULE14) Load, store and copy any register
// (RULE15) Two ops load end counts, one drives outputs
// (RULE16) Separate ops load each far-target register
// (RULE17) Separate ops load product register halves
// (RULE18) All load-type ops take one clock
// (RULE19) Relative target is six-bit field
// (RULE20) Offset signed, sum wraps to ten bits
module microcore_jump_wait_load_unit
	import microcore_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// Instruction stream
	input  wire logic                      instr_valid,
	input  wire microcore_pkg::instr_t     instr,
	output logic                           instr_ready,
	// Fetch address and status
	output logic [ADDR_W-1:0]              micro_program_counter,
	output logic                           waiting,
	// Condition feedback
	input  wire logic [NUM_COND-1:0]       cond_in,
	// Register file read
	output logic [REG_SEL_W-1:0]           reg_rd_sel,
	input  wire logic [DATA_W-1:0]         reg_rd_data,
	// Register file write
	output logic                           reg_wr_en,
	output logic [REG_SEL_W-1:0]           reg_wr_sel,
	output logic [DATA_W-1:0]              reg_wr_data,
	// Data RAM
	output logic [ADDR_W-1:0]              ram_addr,
	input  wire logic [DATA_W-1:0]         ram_rdata,
	output logic                           ram_we,
	output logic [DATA_W-1:0]              ram_wdata,
	// Far-target registers
	output logic [ADDR_W-1:0]              far_target_reg_a,
	output logic [ADDR_W-1:0]              far_target_reg_b,
	// End counts and pre-driver controls
	output logic [DATA_W-1:0]              end_count_reg_1,
	output logic [DATA_W-1:0]              end_count_reg_2,
	output logic [DATA_W-1:0]              end_count_reg_3,
	output logic [DATA_W-1:0]              end_count_reg_4,
	output logic [CTRL_W-1:0]              predriver_ctrl,
	// Product register
	output logic [PROD_W-1:0]              product_register
);

	// Each product half is loaded on its own
	localparam int HALF_W = PROD_W / 2;

	// Reset release through two stages; assertion stays asynchronous so a dead
	// clock cannot keep the sequencer running, while release is clean at the edge
	logic       rst_meta;
	logic       rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// State
	state_t            state;
	state_t            next_state;
	logic [ADDR_W-1:0] pc;
	logic [ADDR_W-1:0] next_pc;

	// Copies of the dedicated registers
	logic [ADDR_W-1:0] far_a;
	logic [ADDR_W-1:0] far_b;
	logic [DATA_W-1:0] end_cnt [NUM_END_CNT];
	logic [CTRL_W-1:0] ctrl;
	logic [PROD_W-1:0] product;

	// True when a taken instruction carries the wanted opcode
	function automatic logic op_hit(input logic taken, input op_t code, input op_t want);
		op_hit = taken && (code == want);
	endfunction

	// Sequencer state decode; an instruction counts only while running
	wire logic              running = (state == ST_RUN);
	wire logic              in_wait = (state == ST_WAIT);
	wire logic              exec    = instr_valid && running;

	// Wait table ops; jumps are steered by the next-value logic directly
	wire logic              do_cwef = op_hit(exec, instr.op, OP_CWEF);
	wire logic              do_cwer = op_hit(exec, instr.op, OP_CWER);
	wire logic              do_wait = op_hit(exec, instr.op, OP_WAIT);

	// Moves between register file and data RAM, and within the register file
	wire logic              do_load = op_hit(exec, instr.op, OP_LOAD);
	wire logic              do_stor = op_hit(exec, instr.op, OP_STORE);
	wire logic              do_copy = op_hit(exec, instr.op, OP_COPY);

	// Dedicated register loads
	wire logic              do_ldca = op_hit(exec, instr.op, OP_LDCA);
	wire logic              do_ldcd = op_hit(exec, instr.op, OP_LDCD);
	wire logic              do_ldph = op_hit(exec, instr.op, OP_LDPH);
	wire logic              do_ldpl = op_hit(exec, instr.op, OP_LDPL);
	wire logic              do_ldfa = op_hit(exec, instr.op, OP_LDFA);
	wire logic              do_ldfb = op_hit(exec, instr.op, OP_LDFB);
	wire logic              do_cnt  = do_ldca || do_ldcd;

	// Branch targets; the relative sum wraps inside the code space rather than
	// faulting, so a jump back from address zero lands near the top
	wire logic [ADDR_W-1:0] rel_dest = rel_target(pc, instr.rel_off); // [RULE19] [RULE20]
	wire logic [ADDR_W-1:0] far_dest = instr.far_sel ? far_b : far_a; // [RULE3]
	wire logic [ADDR_W-1:0] seq_pc   = pc + PC_STEP;

	// Wait table interface
	wait_cfg_t         cfg;
	wait_entry_t       table_q [WAIT_ENTRIES];

	// Match result
	logic              wait_hit;
	logic [ADDR_W-1:0] wait_dest;

	// Entry written with a physical address, so mode never matters later.
	// Both forms resolve the target now; a later far-register load does not
	// move an entry that was already configured.
	assign cfg = '{
		we:   do_cwef || do_cwer, // [RULE8]
		idx:  instr.entry,
		cond: instr.cond,
		dest: do_cwef ? far_dest : rel_dest // [RULE7] [RULE11]
	};

	// Table kept apart so its contents outlive every wait
	wait_table_store #(
		.ENTRIES (WAIT_ENTRIES)
	) u_table (
		.clk     (clk),
		.rst_n   (rst_n),
		.cfg     (cfg),
		.mask_we (do_wait), // [RULE13] [RULE9]
		.mask    (instr.wait_mask),
		.table_q (table_q) // [RULE6]
	);

	// Lowest enabled entry wins when several fire together
	wait_condition_match #(
		.ENTRIES (WAIT_ENTRIES)
	) u_match (
		.table_q (table_q),
		.cond_in (cond_in),
		.hit     (wait_hit),
		.dest    (wait_dest)
	);

	// Only the wait state looks at the match, so a finished wait stops testing.
	// There is no timeout: a wait whose conditions never fire stalls for good.
	wire logic              wait_done = in_wait && wait_hit; // [RULE12]

	// Next program counter and state
	// Every taken instruction settles the counter in its own cycle
	always_comb begin
		next_pc    = pc;
		next_state = state;
		// A pending wait ignores the instruction port entirely
		if (in_wait) begin
			if (wait_done) begin
				next_pc    = wait_dest; // [RULE11]
				next_state = ST_RUN;
			end
		end else if (exec) begin
			unique case (instr.op)
				OP_JMPR: next_pc = rel_dest; // [RULE1] [RULE2]
				OP_JMPF: next_pc = far_dest; // [RULE3] [RULE5]
				OP_WAIT: begin
					next_pc    = pc; // [RULE10]
					next_state = ST_WAIT;
				end
				OP_NOP, OP_CWEF, OP_CWER, OP_LOAD, OP_STORE, OP_COPY,
				OP_LDCA, OP_LDCD, OP_LDPH, OP_LDPL, OP_LDFA, OP_LDFB: begin
					next_pc = seq_pc; // [RULE18]
				end
				// Unassigned code: step over it rather than stall the core
				default: begin
					next_pc = seq_pc;
				end
			endcase
		end
	end

	// Sequencer state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Program counter; held during a wait by the next-value logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= PC_RESET;
		end else begin
			pc <= next_pc;
		end
	end

	// Far-target registers; jumps only read them, so a load may precede use directly
	// Only the dedicated loads write them; no other op has a path in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			far_a <= FAR_RESET;
			far_b <= FAR_RESET;
		end else begin
			if (do_ldfa) begin
				far_a <= instr.imm[ADDR_W-1:0]; // [RULE16] [RULE4]
			end
			if (do_ldfb) begin
				far_b <= instr.imm[ADDR_W-1:0]; // [RULE16] [RULE4]
			end
		end
	end

	// End-count registers and pre-driver controls
	// Both ops share the count path; only one of them also drives the outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_END_CNT; i++) begin
				end_cnt[i] <= DATA_RESET;
			end
			ctrl <= CTRL_RESET;
		end else begin
			if (do_cnt) begin
				end_cnt[instr.cnt_sel] <= reg_rd_data; // [RULE15]
			end
			if (do_ldca) begin
				ctrl <= instr.imm[CTRL_W-1:0]; // [RULE15]
			end
		end
	end

	// Product register halves
	// The half not addressed keeps its value, so either order fills the pair
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			product <= PROD_RESET;
		end else begin
			if (do_ldph) begin
				product[PROD_W-1:HALF_W] <= reg_rd_data; // [RULE17]
			end
			if (do_ldpl) begin
				product[HALF_W-1:0] <= reg_rd_data; // [RULE17]
			end
		end
	end

	// Register file strobes, same cycle as the instruction; combinational so
	// one-clock ops finish, which asks the far side to answer reads at once
	assign reg_rd_sel  = instr.src_sel;
	assign reg_wr_en   = do_load || do_copy; // [RULE14] [RULE18]
	assign reg_wr_sel  = instr.dst_sel;
	assign reg_wr_data = do_load ? ram_rdata : reg_rd_data; // [RULE14]

	// Data RAM side; the write data is always the selected register
	assign ram_addr    = instr.ram_addr;
	assign ram_we      = do_stor; // [RULE14]
	assign ram_wdata   = reg_rd_data;

	// Handshake and status, straight from the state register; fetch address straight from the program counter
	assign instr_ready           = running;
	assign waiting               = in_wait;
	assign micro_program_counter = pc;

	// Register contents
	assign far_target_reg_a      = far_a;
	assign far_target_reg_b      = far_b;
	assign end_count_reg_1       = end_cnt[0];
	assign end_count_reg_2       = end_cnt[1];
	assign end_count_reg_3       = end_cnt[2];
	assign end_count_reg_4       = end_cnt[3];
	assign predriver_ctrl        = ctrl;
	assign product_register      = product;

endmodule
`default_nettype wire

/* testbench/mc_far_side.sv */
// Far-side model: register file and data RAM of one microcore.
// Assumes reads are combinational and writes land on the taking edge.
`timescale 1ns/1ps
`default_nettype none
module mc_far_side
	import microcore_pkg::*;
(
	// Clock
	input  wire logic                 clk,
	// Register file
	input  wire logic [REG_SEL_W-1:0] reg_rd_sel,
	output logic [DATA_W-1:0]         reg_rd_data,
	input  wire logic                 reg_wr_en,
	input  wire logic [REG_SEL_W-1:0] reg_wr_sel,
	input  wire logic [DATA_W-1:0]    reg_wr_data,
	// Data RAM
	input  wire logic [ADDR_W-1:0]    ram_addr,
	output logic [DATA_W-1:0]         ram_rdata,
	input  wire logic                 ram_we,
	input  wire logic [DATA_W-1:0]    ram_wdata
);
	logic [DATA_W-1:0] regs [32];
	logic [DATA_W-1:0] ram [1024];
	// Address-tagged contents so every read is traceable
	initial begin
		for (int i = 0; i < 1024; i++) begin
			ram[i] = 16'hC000 | 16'(i);
			if (i < 32) regs[i] = 16'h1000 | 16'(i);
		end
	end
	// Instant reads, else one-clock ops could not finish in time
	assign reg_rd_data = regs[reg_rd_sel];
	assign ram_rdata = ram[ram_addr];
	// Writes at the edge that takes the op
	always @(posedge clk) begin
		if (reg_wr_en) regs[reg_wr_sel] <= reg_wr_data;
		if (ram_we) ram[ram_addr] <= ram_wdata;
	end
endmodule
`default_nettype wire

/* testbench/mc_unit_props.sv */
// Port checker for the jump, wait and load unit.
// Assumes the unit's port names; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module mc_unit_props
	import microcore_pkg::*;
(
	// Clock, reset, instruction
	input wire logic                  clk,
	input wire logic                  nrst,
	input wire logic                  instr_valid,
	input wire microcore_pkg::instr_t instr,
	input wire logic                  instr_ready,
	input wire logic [ADDR_W-1:0]     micro_program_counter,
	input wire logic                  waiting,
	// Data paths
	input wire logic [DATA_W-1:0]     reg_rd_data,
	input wire logic                  reg_wr_en,
	input wire logic [DATA_W-1:0]     reg_wr_data,
	input wire logic [DATA_W-1:0]     ram_rdata,
	input wire logic                  ram_we,
	input wire logic [DATA_W-1:0]     ram_wdata,
	// Dedicated registers
	input wire logic [ADDR_W-1:0]     far_target_reg_a,
	input wire logic [ADDR_W-1:0]     far_target_reg_b,
	input wire logic [DATA_W-1:0]     end_count_reg_4,
	input wire logic [PROD_W-1:0]     product_register
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Instruction accepted in this cycle
	sequence s_take(op_t o);
		instr_valid && instr_ready && instr.op == o;
	endsequence
	AST_JMPR: assert property (s_take(OP_JMPR) |=> micro_program_counter ==
		$past(micro_program_counter) + {{4{$past(instr.rel_off[5])}}, $past(instr.rel_off)})
		else $error("relative jump target wrong");
	AST_JMPF: assert property (s_take(OP_JMPF) |=> $stable(far_target_reg_a) &&
		micro_program_counter == ($past(instr.far_sel) ? far_target_reg_b : far_target_reg_a))
		else $error("far jump wrong");
	AST_LDFA: assert property (s_take(OP_LDFA) |=> far_target_reg_a == $past(instr.imm[9:0]))
		else $error("far register a load wrong");
	AST_LOAD: assert property (s_take(OP_LOAD) |-> reg_wr_en && reg_wr_data == ram_rdata)
		else $error("load strobe wrong");
	AST_STORE: assert property (s_take(OP_STORE) |-> ram_we && ram_wdata == reg_rd_data)
		else $error("store strobe wrong");
	AST_LDCA: assert property (s_take(OP_LDCA) ##0 instr.cnt_sel == 2'h3 |=>
		end_count_reg_4 == $past(reg_rd_data)) else $error("end count load wrong");
	AST_LDPH: assert property (s_take(OP_LDPH) |=> product_register[31:16] == $past(reg_rd_data))
		else $error("product high load wrong");
	AST_WAIT_IN: assert property (s_take(OP_WAIT) |=> waiting && !instr_ready)
		else $error("wait not entered");
	AST_WAIT_HOLD: assert property (waiting ##1 waiting |-> $stable(micro_program_counter))
		else $error("counter moved while waiting");
endmodule
bind microcore_jump_wait_load_unit mc_unit_props i_props (.clk, .nrst, .instr_valid, .instr, .instr_ready,
	.micro_program_counter, .waiting, .reg_rd_data, .reg_wr_en, .reg_wr_data, .ram_rdata, .ram_we, .ram_wdata,
	.far_target_reg_a, .far_target_reg_b, .end_count_reg_4, .product_register);
`default_nettype wire

/* testbench/tb_microcore_jump_wait_load_unit.sv */
// Self-checking bench for the jump, wait and load unit.
// Assumes the far-side model answers reads at once.
`timescale 1ns/1ps
`default_nettype none
module tb_microcore_jump_wait_load_unit;
	import microcore_pkg::*;
	logic clk = 0, nrst = 0, instr_valid = 0, instr_ready, waiting, reg_wr_en, ram_we;
	instr_t instr = '0;
	logic [NUM_COND-1:0] cond_in = '0;
	logic [ADDR_W-1:0] micro_program_counter, ram_addr, far_target_reg_a, far_target_reg_b;
	logic [REG_SEL_W-1:0] reg_rd_sel, reg_wr_sel;
	logic [DATA_W-1:0] reg_rd_data, reg_wr_data, ram_rdata, ram_wdata;
	logic [DATA_W-1:0] end_count_reg_1, end_count_reg_2, end_count_reg_3, end_count_reg_4;
	logic [CTRL_W-1:0] predriver_ctrl;
	logic [PROD_W-1:0] product_register;
	int failures = 0, check_count = 0;
	microcore_jump_wait_load_unit i_dut (.clk, .nrst, .instr_valid, .instr, .instr_ready, .micro_program_counter,
		.waiting, .cond_in, .reg_rd_sel, .reg_rd_data, .reg_wr_en, .reg_wr_sel, .reg_wr_data, .ram_addr, .ram_rdata,
		.ram_we, .ram_wdata, .far_target_reg_a, .far_target_reg_b, .end_count_reg_1, .end_count_reg_2,
		.end_count_reg_3, .end_count_reg_4, .predriver_ctrl, .product_register);
	mc_far_side i_far (.clk, .reg_rd_sel, .reg_rd_data, .reg_wr_en, .reg_wr_sel, .reg_wr_data, .ram_addr,
		.ram_rdata, .ram_we, .ram_wdata);
	always #4 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One op per edge; a drives source, entry, count and far selects and the mask, b offsets, codes, destination select and RAM address
	task automatic drv(op_t op, logic [5:0] a = 0, logic [5:0] b = 0, logic [15:0] m = 0, logic [63:0] c = 0);
		@(posedge clk);
		instr <= '{op, a[0], b, a[2:0], b, a[4:0], a[4:0], b[4:0], a[1:0], {4'h0, b}, m};
		instr_valid <= 1'b1;
		cond_in <= c;
		@(negedge clk);
	endtask
	task automatic t_jumps();
		drv(OP_NOP);
		drv(OP_JMPR, 0, 6'h3E);
		drv(OP_LDFA, 0, 0, 16'h0123);
		chk(micro_program_counter, 10'h3FF, "jmpr");
		drv(OP_JMPF, 6'h00);
		drv(OP_LDFB, 0, 0, 16'h02AA);
		chk(micro_program_counter, 10'h123, "jmpf a");
		chk(far_target_reg_a, 10'h123, "far a kept");
		drv(OP_JMPF, 6'h01);
		chk(far_target_reg_b, 10'h2AA, "far b load");
		drv(OP_NOP);
		chk(micro_program_counter, 10'h2AA, "jmpf b");
		chk({reg_wr_en, ram_we}, 2'b00, "no strobe on nop");
		$display("jumps done");
	endtask
	task automatic t_loads();
		logic [9:0] p;
		drv(OP_LOAD, 0, 6'h05);
		chk({reg_wr_en, reg_wr_sel, reg_wr_data}, {1'b1, 5'h05, 16'hC005}, "load");
		drv(OP_COPY, 6'h05, 6'h07);
		chk({reg_rd_sel, reg_wr_en, reg_wr_sel, reg_wr_data}, {5'h05, 1'b1, 5'h07, 16'hC005}, "copy");
		drv(OP_STORE, 6'h07, 6'h09);
		chk({ram_we, ram_addr, ram_wdata}, {1'b1, 10'h009, 16'hC005}, "store");
		p = micro_program_counter;
		drv(OP_LOAD, 0, 6'h09);
		chk({reg_wr_data, 6'h00, micro_program_counter}, {16'hC005, 6'h00, p + 10'h001}, "reload");
		$display("loads done");
	endtask
	task automatic t_dedicated();
		drv(OP_LDCA, 6'h03, 0, 16'h000A);
		drv(OP_LDCD, 6'h01);
		chk({end_count_reg_4, predriver_ctrl}, {16'h1003, 4'hA}, "ldca");
		drv(OP_LDPH, 6'h02);
		chk({end_count_reg_2, predriver_ctrl}, {16'h1001, 4'hA}, "ldcd");
		drv(OP_LDPL, 6'h04);
		drv(OP_NOP);
		chk(product_register, 32'h1002_1004, "product");
		chk({end_count_reg_1, end_count_reg_3}, {DATA_RESET, DATA_RESET}, "other counts kept");
		$display("dedicated done");
	endtask
	task automatic t_wait();
		logic [9:0] p, q;
		drv(OP_CWEF, 6'h01, 6'd10);
		drv(OP_CWER, 6'h02, 6'h04);
		p = micro_program_counter + 10'h004;
		drv(OP_WAIT, 6'h06);
		drv(OP_NOP);
		chk({waiting, instr_ready}, 2'b10, "enter wait");
		q = micro_program_counter;
		drv(OP_NOP);
		drv(OP_NOP, 0, 0, 0, 64'h10);
		chk({waiting, micro_program_counter}, {1'b1, q}, "held");
		drv(OP_NOP, 0, 0, 0, 64'h10);
		chk({waiting, micro_program_counter}, {1'b0, p}, "rel exit");
		drv(OP_WAIT, 6'h02, 0, 0, 64'h10);
		chk(micro_program_counter, p + 10'h001, "no rewait");
		drv(OP_NOP, 0, 0, 0, 64'h10);
		drv(OP_NOP, 0, 0, 0, 64'h400);
		chk(waiting, 1'b1, "entry masked");
		drv(OP_NOP);
		chk({waiting, micro_program_counter}, {1'b0, 10'h2AA}, "far exit");
		$display("wait done");
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_jumps();
		t_loads();
		t_dedicated();
		t_wait();
		close_out();
	end
	// About 47 cycles expected; far more means a hang
	initial begin
		#20000;
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
